// *** hw/lbwb_bridge.sv ***
// local bus slave that bridges single cycles onto a shared wishbone bus
// What this block does
// - bus reset comes from local reset input, clock from system clock.
// - internal bus is 32-bit shared, single read and write only.
// - upper address bits select exactly one slave per cycle.
// - each local single cycle becomes one wishbone cycle.
// - bursts are refused, never forwarded to the internal bus.
// - burst last marks final data cycle; ignored in single cycles.
// - transfer ready low means write taken or read data valid.
// - wait states are made by holding back transfer ready.
// - burst terminate low ends a burst; controller restarts addressing.
// - burst terminate mirrors transfer ready, forcing single cycles.
// - read data drives all 32 lines while transfer ready asserts.
// - address/data drivers float outside read data phases.
// - unused controller control lines are left undriven and unpulled.
// - byte address shifts right two bits to form the word address.
// - slave acknowledge delay delays transfer ready equally.
// - hold request is returned as hold acknowledge.
`timescale 1ns/10ps
module lbwb_bridge (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  system_clock_in,
  input  wire logic                  local_reset_n,
  input  wire logic                  local_bus_clock,
  input  wire logic                  address_strobe_n,
  input  wire logic                  write_not_read,
  input  wire logic                  burst_last_n,
  input  wire logic [31:0]           muxed_addr_data_i,
  output      logic [31:0]           muxed_addr_data_o,
  output      logic                  muxed_addr_data_oe,
  output      logic                  ready_n,
  output      logic                  burst_terminate_n,
  input  wire logic                  hold_request,
  output      logic                  hold_acknowledge,
  output      logic                  bus_rst,
  output      logic                  bus_clk,
  output      logic                  wb_stb_o,
  output      logic                  wb_cyc_o,
  output      logic                  wb_we_o,
  output      logic [31:0]           wb_adr_o,
  output      logic [31:0]           wb_dat_o,
  output      logic [3:0]            wb_sel_o,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_ack_i
);
  import lbwb_pkg::*;

  // ---------------------------------------------------------------
  // synchronisers: every link pin but the unused burst_last_n passes two flops
  // ---------------------------------------------------------------
  // the link clock is oversampled; its edges are found in the ref_clk domain
  logic [1:0]  local_bus_clock_s_q;
  logic [1:0]  ads_s_q;
  logic [1:0]  wnr_s_q;
  logic [1:0]  hold_s_q;
  logic [1:0]  lrst_s_q;
  logic [1:0]  sclk_s_q;
  logic [31:0] lad_s1_q;
  logic [31:0] lad_s2_q;
  logic        local_bus_clock_d1_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      local_bus_clock_s_q <= SYNC_RST;
      ads_s_q  <= SYNC_RST_HI;
      wnr_s_q  <= SYNC_RST;
      hold_s_q <= SYNC_RST;
      lrst_s_q <= SYNC_RST;
      sclk_s_q <= SYNC_RST;
      lad_s1_q <= DATA_RST;
      lad_s2_q <= DATA_RST;
      local_bus_clock_d1_q <= 1'b0;
    end else begin
      local_bus_clock_s_q <= {local_bus_clock_s_q[0], local_bus_clock};
      ads_s_q  <= {ads_s_q[0], address_strobe_n};
      wnr_s_q  <= {wnr_s_q[0], write_not_read};
      hold_s_q <= {hold_s_q[0], hold_request};
      lrst_s_q <= {lrst_s_q[0], local_reset_n};
      sclk_s_q <= {sclk_s_q[0], system_clock_in};
      lad_s1_q <= muxed_addr_data_i;
      lad_s2_q <= lad_s1_q;
      local_bus_clock_d1_q <= local_bus_clock_s_q[1];
    end
  end

  // burst_last_n is unused: bursts are cut to singles, so it carries nothing
  // lad is taken two flops late, in step with the strobe and link clock copies
  wire local_bus_clock_rise = local_bus_clock_s_q[1] & ~local_bus_clock_d1_q;
  wire local_bus_clock_fall = ~local_bus_clock_s_q[1] & local_bus_clock_d1_q;
  wire ads_low   = ~ads_s_q[1];
  wire in_reset  = ~lrst_s_q[1];

  // ---------------------------------------------------------------
  // system signals
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_rst          <= 1'b1;
      bus_clk          <= 1'b0;
      hold_acknowledge <= 1'b0;
    end else begin
      bus_rst          <= in_reset;
      bus_clk          <= sclk_s_q[1];
      hold_acknowledge <= hold_s_q[1];
    end
  end

  // ---------------------------------------------------------------
  // cycle engine
  // ---------------------------------------------------------------
  lbwb_state_t state_q, state_d;
  lbwb_req_t   req_q;
  wire         any_ack  = |wb_ack_i;
  wire [31:0]  word_adr = lbwb_word_addr(lad_s2_q);
  logic        rsp_ready, rsp_valid;
  lbwb_rsp_t   rsp_data;
  wire         buf_in_ready;
  // write data goes out on the same edge as the strobe, not one cycle behind it
  wire         take_dat = (state_q == ST_ADDR) && local_bus_clock_rise;
  wire [31:0]  dat_next = take_dat ? lad_s2_q : req_q.dat;

  // ready goes out only once the answer is ready; wait states follow ack
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (local_bus_clock_rise && ads_low) state_d = ST_ADDR;
      ST_ADDR: if (local_bus_clock_rise) state_d = ST_WB;
      ST_WB:   if (any_ack && buf_in_ready) state_d = ST_RDY;
      // leave only on a link fall seen after ready went out, so that ready
      // still stands at the controller's next rising edge
      ST_RDY:  if ((rsp_valid || req_q.we) && local_bus_clock_fall) state_d = ST_GAP;
      ST_GAP:  if (local_bus_clock_rise) state_d = ST_IDLE;
    endcase
  end

  // a local reset drains any answer that was never handed out
  assign rsp_ready = ((state_q == ST_GAP) && local_bus_clock_rise) || in_reset;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      req_q   <= '0;
    end else if (in_reset) begin
      state_q <= ST_IDLE;
      req_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && local_bus_clock_rise && ads_low) begin
        req_q.we  <= wnr_s_q[1];
        req_q.adr <= word_adr;
      end
      if (state_q == ST_ADDR && local_bus_clock_rise) begin
        req_q.dat <= lad_s2_q;
      end
    end
  end

  // request held steady until acknowledge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_stb_o <= 1'b0;
      wb_cyc_o <= 1'b0;
      wb_we_o  <= 1'b0;
      wb_adr_o <= ADDR_RST;
      wb_dat_o <= DATA_RST;
      wb_sel_o <= 4'h0;
    end else begin
      wb_stb_o <= (state_d == ST_WB) && !(state_q == ST_WB && any_ack);
      wb_cyc_o <= (state_d == ST_WB) && !(state_q == ST_WB && any_ack);
      wb_we_o  <= req_q.we;
      wb_adr_o <= req_q.adr;
      wb_dat_o <= dat_next;
      wb_sel_o <= 4'h1 << lbwb_slave_sel(req_q.adr);
    end
  end

  // ---------------------------------------------------------------
  // read answer path
  // ---------------------------------------------------------------
  lbwb_buf lbwb_buf_i (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (state_q == ST_WB && any_ack && !req_q.we),
    .in_ready  (buf_in_ready),
    .in_data   (lbwb_rsp_t'(wb_dat_i)),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data)
  );

  // ---------------------------------------------------------------
  // local bus outputs
  // ---------------------------------------------------------------
  // ready and terminate share one source so they can never drift apart
  wire rdy_now = (state_q == ST_RDY || state_q == ST_GAP);
  wire rd_out  = rdy_now && !req_q.we;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ready_n            <= 1'b1;
      burst_terminate_n  <= 1'b1;
      muxed_addr_data_o  <= DATA_RST;
      muxed_addr_data_oe <= 1'b0;
    end else begin
      ready_n            <= ~rdy_now;
      burst_terminate_n  <= ~rdy_now;
      muxed_addr_data_o  <= rd_out ? rsp_data.dat : DATA_RST;
      muxed_addr_data_oe <= rd_out;
    end
  end

endmodule : lbwb_bridge

// *** hw/lbwb_buf.sv ***
// two-entry valid/ready buffer carrying read answers toward the local bus
`timescale 1ns/10ps
module lbwb_buf (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              in_valid,
  output      logic              in_ready,
  input  wire lbwb_pkg::lbwb_rsp_t in_data,
  output      logic              out_valid,
  input  wire logic              out_ready,
  output      lbwb_pkg::lbwb_rsp_t out_data
);
  import lbwb_pkg::*;

  lbwb_rsp_t  mem_q [BUF_DEPTH];
  logic       wr_q;
  logic       rd_q;
  logic [1:0] cnt_q;
  wire        push = in_valid & in_ready;
  wire        pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != 2'(BUF_DEPTH));
  assign out_valid = (cnt_q != CNT_RST);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= CNT_RST;
    end else begin
      wr_q  <= wr_q ^ push;
      rd_q  <= rd_q ^ pop;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  // storage needs no reset; only the count cnt_q defines validity
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : lbwb_buf

// *** inc/lbwb_pkg.sv ***
// package: constants and carrier types for the local bus to wishbone bridge
package lbwb_pkg;

  // ---------------------------------------------------------------
  // bus widths and slave decode
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned SEL_W        = 2;
  localparam int unsigned NUM_SLAVES   = 4;
  localparam int unsigned SEL_MSB      = 29;
  localparam int unsigned WORD_SHIFT   = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
  localparam logic [31:0] DATA_RST     = 32'h0000_0000;
  localparam logic [1:0]  SYNC_RST     = 2'h0;
  localparam logic [1:0]  SYNC_RST_HI  = 2'h3;

  // ---------------------------------------------------------------
  // buffer
  // ---------------------------------------------------------------
  localparam int unsigned BUF_DEPTH    = 2;
  localparam logic [1:0]  CNT_RST      = 2'h0;

  typedef struct packed {
    logic        we;
    logic [31:0] adr;
    logic [31:0] dat;
  } lbwb_req_t;

  typedef struct packed {
    logic [31:0] dat;
  } lbwb_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WB,
    ST_RDY,
    ST_GAP
  } lbwb_state_t;

  // byte address to word address, slave select from upper bits
  function automatic logic [31:0] lbwb_word_addr(input logic [31:0] a);
    return a >> WORD_SHIFT;
  endfunction : lbwb_word_addr

  function automatic logic [SEL_W-1:0] lbwb_slave_sel(input logic [31:0] w);
    return w[SEL_MSB -: SEL_W];
  endfunction : lbwb_slave_sel

endpackage : lbwb_pkg

// *** test/lbwb_bridge_assertions.sv ***
// checker: bridge port assertions
`timescale 1ns/10ps
module lbwb_bridge_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        system_clock_in,
  input wire logic        local_reset_n,
  input wire logic        hold_request,
  input wire logic        hold_acknowledge,
  input wire logic        bus_rst,
  input wire logic        bus_clk,
  input wire logic        ready_n,
  input wire logic        burst_terminate_n,
  input wire logic        muxed_addr_data_oe,
  input wire logic        wb_stb_o,
  input wire logic        wb_cyc_o,
  input wire logic        wb_we_o,
  input wire logic [31:0] wb_adr_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0]  wb_sel_o,
  input wire logic [3:0]  wb_ack_i
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----
  // handshake phases
  // ----
  sequence s_waiting;
    wb_stb_o && !(|wb_ack_i);
  endsequence
  sequence s_acked;
    wb_stb_o && (|wb_ack_i);
  endsequence
  a_burst_terminate_n_mirror: assert property (burst_terminate_n == ready_n) else $error("burst_terminate_n differs");
  a_float_idle: assert property (muxed_addr_data_oe |-> !ready_n) else $error("bus driven");
  a_req_stable: assert property (s_waiting |=> wb_stb_o && $stable(wb_adr_o) && $stable(wb_dat_o)
    && $stable(wb_we_o)) else $error("request moved");
  a_single_cyc: assert property (s_acked |=> !wb_stb_o) else $error("strobe after ack");
  a_ack_ready: assert property (s_acked |-> ##[2:3] !ready_n) else $error("ready late");
  a_slave_sel: assert property (wb_stb_o |-> wb_cyc_o && wb_sel_o == 4'h1 << wb_adr_o[29:28])
    else $error("bad select");
  a_hold_loop: assert property (hold_request [*4] |-> hold_acknowledge) else $error("no hold ack");
  a_bus_reset: assert property (!local_reset_n [*4] |-> bus_rst) else $error("no bus reset");
  a_bus_clock: assert property (system_clock_in [*4] |-> bus_clk) else $error("bus clock");
endmodule : lbwb_bridge_assertions
bind lbwb_bridge lbwb_bridge_assertions lbwb_bridge_assertions_i (
  .ref_clk            (ref_clk),
  .rst                (rst),
  .system_clock_in    (system_clock_in),
  .local_reset_n      (local_reset_n),
  .hold_request       (hold_request),
  .hold_acknowledge   (hold_acknowledge),
  .bus_rst            (bus_rst),
  .bus_clk            (bus_clk),
  .ready_n            (ready_n),
  .burst_terminate_n  (burst_terminate_n),
  .muxed_addr_data_oe (muxed_addr_data_oe),
  .wb_stb_o           (wb_stb_o),
  .wb_cyc_o           (wb_cyc_o),
  .wb_we_o            (wb_we_o),
  .wb_adr_o           (wb_adr_o),
  .wb_dat_o           (wb_dat_o),
  .wb_sel_o           (wb_sel_o),
  .wb_ack_i           (wb_ack_i)
);

// *** test/lbwb_bridge_tb.sv ***
// testbench: local bus cycles through the bridge into a wishbone slave
`timescale 1ns/10ps
module lbwb_bridge_tb;
  import lbwb_pkg::*;
  logic        ref_clk, rst, system_clock_in, local_reset_n, hold_request, local_bus_clock;
  logic        address_strobe_n, write_not_read, burst_last_n, muxed_addr_data_oe, ready_n;
  logic        burst_terminate_n, hold_acknowledge, bus_rst, bus_clk, wb_stb_o, wb_cyc_o, wb_we_o, cap_we;
  logic [31:0] muxed_addr_data_o, lad_m, wb_adr_o, wb_dat_o, wb_dat_i, cap_adr, cap_dat;
  logic [3:0]  wb_sel_o, wb_ack_i, cap_sel;
  logic [2:0]  div = 3'h0;
  wire  [31:0] lad = muxed_addr_data_oe ? muxed_addr_data_o : lad_m;
  int          mismatches = 0, comparisons = 0, dly = 0, wt = 0;
  lbwb_bridge lbwb_bridge_i (.ref_clk, .rst, .system_clock_in, .local_reset_n, .local_bus_clock,
    .address_strobe_n, .write_not_read, .burst_last_n, .muxed_addr_data_i(lad), .muxed_addr_data_o,
    .muxed_addr_data_oe, .ready_n, .burst_terminate_n, .hold_request, .hold_acknowledge, .bus_rst,
    .bus_clk, .wb_stb_o, .wb_cyc_o, .wb_we_o, .wb_adr_o, .wb_dat_o, .wb_sel_o, .wb_dat_i, .wb_ack_i);
  lbwb_lb_master lbwb_lb_master_i (.local_bus_clock, .address_strobe_n, .write_not_read,
    .burst_last_n, .lad_m, .ready_n, .lad);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ----
  // wishbone slave, dly wait states
  // ----
  always @(posedge ref_clk) begin
    div <= div + 3'h1;
    system_clock_in <= div[2];
    wb_ack_i <= 4'h0;
    if (wb_stb_o && wb_cyc_o && wb_ack_i == 4'h0) begin
      wt <= wt + 1;
      if (wt >= dly) begin
        wt <= 0;
        wb_ack_i <= wb_sel_o;
        wb_dat_i <= ~wb_adr_o;
        {cap_we, cap_adr, cap_dat, cap_sel} <= {wb_we_o, wb_adr_o, wb_dat_o, wb_sel_o};
      end
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [31:0] a, d, output logic [31:0] q);
    bit ok;
    @(negedge ref_clk);
    lbwb_lb_master_i.cyc_t(we, a, d, q, ok);
    chk({31'h0, ok}, 32'h1, "ready");
    if (!ok) begin
      conclude();
    end
    chk(cap_adr, a >> 2, "word address");
    chk({31'h0, cap_we}, {31'h0, we}, "direction");
    chk({28'h0, cap_sel}, 32'h1 << a[31:30], "select");
  endtask : xfer
  task automatic t_writes;
    logic [31:0] q;
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, {s[1:0], 30'h0123_4564}, 32'hC0DE_0000 + s, q);
      chk(cap_dat, 32'hC0DE_0000 + s, "write data");
    end
  endtask : t_writes
  task automatic t_reads;
    logic [31:0] q;
    logic [31:0] a;
    for (int w = 0; w < 4; w++) begin
      dly = w * 2;
      a = 32'h4000_0ABC + 32'(w * 4);
      xfer(1'b0, a, 32'h0, q);
      chk(q, ~(a >> 2), "read data");
    end
  endtask : t_reads
  task automatic t_sys;
    for (int v = 1; v >= 0; v--) begin
      @(posedge ref_clk);
      hold_request <= v[0];
      local_reset_n <= ~v[0];
      repeat (5) @(negedge ref_clk);
      chk({31'h0, hold_acknowledge}, v, "hold ack");
      chk({31'h0, bus_rst}, v, "bus reset");
    end
  endtask : t_sys
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    rst = 1'b1;
    local_reset_n = 1'b1;
    hold_request = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_writes();
    t_sys();
    t_reads();
    conclude();
  end
endmodule : lbwb_bridge_tb

// *** test/lbwb_lb_master.sv ***
// partner model: local bus master issuing single cycles
`timescale 1ns/10ps
module lbwb_lb_master (
  output      logic        local_bus_clock,
  output      logic        address_strobe_n,
  output      logic        write_not_read,
  output      logic        burst_last_n,
  output      logic [31:0] lad_m,
  input  wire logic        ready_n,
  input  wire logic [31:0] lad
);
  // link clock stands still between frames
  initial begin
    local_bus_clock = 1'b0;
    address_strobe_n = 1'b1;
    write_not_read = 1'b0;
    burst_last_n = 1'b1;
    lad_m = 32'h0;
  end
  // link runs far slower than the real controller so the sampler sees every edge
  task automatic half(input logic lvl);
    #200;
    local_bus_clock = lvl;
  endtask : half
  task automatic cyc_t(input logic we, input logic [31:0] a, d, output logic [31:0] q, output bit ok);
    ok = 1'b0;
    q = 32'h0;
    write_not_read = we;
    lad_m = a;
    address_strobe_n = 1'b0;
    burst_last_n = 1'b0;
    half(1'b1);
    half(1'b0);
    address_strobe_n = 1'b1;
    lad_m = we ? d : ~a;
    for (int n = 0; n < 40 && !ok; n++) begin
      half(1'b1);
      if (ready_n === 1'b0) begin
        ok = 1'b1;
        q = lad;
      end
      half(1'b0);
      // released lines must not echo a stale word
      if (!we) lad_m = ~lad_m;
    end
    burst_last_n = 1'b1;
    lad_m = ~lad_m;
    half(1'b1);
    half(1'b0);
  endtask : cyc_t
endmodule : lbwb_lb_master
